// ==== inc/gpmc_pkg.sv ====
// Function
// - Wake threshold: 01/1,10/0 2.5 mV; 10/1,11/0 5 mV; 11/1 10 mV.
// - Range-select 00 turns the wake comparator off regardless of range bit.
// - Comparator crossing in either current direction raises an internal interrupt.
// - Flash programming refused unless voltage reaches flash minimum, default 2800 mV.
// - Exactly three power modes; normal whenever no other mode is active.
// - Normal mode measures, refreshes the data set and evaluates mode changes.
// - Idle entry needs idle-enable set and mean current below idle current.
// - Offset calibration runs after idle entry qualifies, before idle begins.
// - Idle wakes periodically, measures, updates data, returns straight to idle.
// - Idle exits on broken entry condition, protection change or wake trip.
// - Idle with nonzero delay counts down, entering deep idle at zero.
// - Deep-idle delay of zero disables deep idle completely.
// - Deep idle stops the fast oscillator yet keeps periodic measurements.
// - Any host line activity ends deep idle.
// - Deep-idle command sets the flag; a readback may already see it clear.
// - Deep idle may hold the line low up to 4 ms; host tolerates.
// - Single-wire wake from deep idle discards the first host message.
`default_nettype none
package gpmc_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_IDLE_CUR = 6'h04;
  localparam logic [5:0] REG_DEEP_DLY = 6'h08;
  localparam logic [5:0] REG_FLASH_MIN = 6'h0C;
  localparam logic [5:0] REG_STATUS = 6'h10;
  localparam logic [5:0] REG_CMD = 6'h14;
  localparam logic [5:0] REG_IRQ_STAT = 6'h18;
  localparam logic [5:0] REG_IRQ_MASK = 6'h1C;
  localparam logic [5:0] REG_THRESH = 6'h20;
  // Control field positions
  localparam int CTRL_IDLE_EN = 0;
  localparam int CTRL_SEL_LO = 1;
  localparam int CTRL_SEL_HI = 2;
  localparam int CTRL_WAKE_BIT = 3;
  // Interrupt bit positions
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_MODE = 1;
  localparam int IRQ_FLASH = 2;
  localparam int IRQ_W = 3;
  // Values after reset
  localparam logic [3:0] CTRL_RST = 4'h1;
  localparam logic [15:0] IDLE_CUR_RST = 16'h000A;
  localparam logic [15:0] DEEP_DLY_RST = 16'h0000;
  localparam logic [15:0] FLASH_MIN_RST = 16'h0AF0;
  // Wake thresholds in microvolts
  localparam logic [15:0] TH_1P25 = 16'h04E2;
  localparam logic [15:0] TH_2P5 = 16'h09C4;
  localparam logic [15:0] TH_5 = 16'h1388;
  localparam logic [15:0] TH_10 = 16'h2710;
  // Line stall time and its cycle count at the clock rate
  localparam int CLK_MHZ = 200;
  localparam int STALL_TIME_US = 4000;
  localparam int STALL_CYC = STALL_TIME_US * CLK_MHZ;
  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {ST_NORMAL, ST_CAL, ST_IDLE, ST_DEEP, ST_STALL} gpmc_state_t;
  typedef enum logic [1:0] {PM_NORMAL, PM_IDLE, PM_DEEP} gpmc_pmode_t;
  typedef struct packed {
    logic signed [15:0] mean_current_reading;
    logic [15:0] voltage_mv;
    logic signed [15:0] sense_uv;
  } gpmc_meas_t;
endpackage
`default_nettype wire

// ==== rtl/gpmc_top.sv ====
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module gpmc_top
#(
  parameter int unsigned STALL_CYC = gpmc_pkg::STALL_CYC
)
(
  // Clock, reset, clock enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // Avalon-MM register slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Measurement front end
  input wire gpmc_pkg::gpmc_meas_t meas,
  input wire logic meas_tick,
  input wire logic [7:0] prot_status,
  input wire logic adc_cal_done,
  output logic meas_start,
  output logic dataset_update,
  output logic adc_cal_start,
  // Data flash write gate
  input wire logic flash_write_req,
  output logic flash_write_grant,
  // Host serial line
  input wire logic comm_line_i,
  input wire logic single_wire_mode,
  input wire logic msg_done,
  output logic comm_line_o,
  output logic comm_line_oe,
  output logic drop_next_msg,
  // Power mode and interrupt
  output var gpmc_pkg::gpmc_pmode_t power_mode,
  output logic hf_osc_en,
  output logic wake_trip,
  output logic irq
);
  import gpmc_pkg::*;

  localparam int SW = $clog2(STALL_CYC + 1);

  logic [3:0] ctrl;
  logic [15:0] idle_cur;
  logic [15:0] deep_dly;
  logic [15:0] flash_min;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_ev;
  logic deep_idle_flag;
  logic ack;
  logic reg_wr;
  logic cmd_wr;
  logic [31:0] rd_cur;
  logic [31:0] wdat;
  logic [31:0] lane_dat;
  gpmc_state_t state;
  gpmc_state_t next_state;
  logic [15:0] dcount;
  logic [SW-1:0] stall_cnt;
  logic [2:0] line_s;
  logic line_lvl;
  logic comm_act;
  logic [7:0] prot_prev;
  logic prot_chg;
  logic [15:0] thresh;
  logic [15:0] cur_mag;
  logic signed [16:0] th_s;
  logic signed [16:0] sense_x;
  logic trip_now;
  logic qual;
  logic flash_ok;
  logic [SW-1:0] oe_run;

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Byte-lane merge of write data onto an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction

  // Wake threshold from {select high, select low, range bit}
  function automatic logic [15:0] wake_th(input logic [2:0] s);
    case (s)
      3'b010: wake_th = TH_1P25;
      3'b011, 3'b100: wake_th = TH_2P5;
      3'b101, 3'b110: wake_th = TH_5;
      3'b111: wake_th = TH_10;
      default: wake_th = 16'h0000;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  // One wait state, then the request is answered
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign reg_wr = ce && avs_write && ack;
  assign wdat = be_merge(rd_cur, avs_writedata, avs_byteenable);
  assign lane_dat = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
  assign cmd_wr = reg_wr && avs_address == REG_CMD && lane_dat[0];

  // Handshake flop
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      ack <= 1'b0;
    else if (ce)
      ack <= (avs_read || avs_write) && !ack;
  end

  // Readback of the addressed word
  always_comb
  begin
    case (avs_address)
      REG_CTRL: rd_cur = {28'h000_0000, ctrl};
      REG_IDLE_CUR: rd_cur = {16'h0000, idle_cur};
      REG_DEEP_DLY: rd_cur = {16'h0000, deep_dly};
      REG_FLASH_MIN: rd_cur = {16'h0000, flash_min};
      REG_STATUS: rd_cur = {dcount, 9'h000, drop_next_msg, wake_trip,
                            deep_idle_flag, hf_osc_en, 1'b0, power_mode};
      REG_IRQ_STAT: rd_cur = {29'h0000_0000, irq_stat};
      REG_IRQ_MASK: rd_cur = {29'h0000_0000, irq_mask};
      REG_THRESH: rd_cur = {16'h0000, thresh};
      default: rd_cur = 32'h0000_0000;
    endcase
  end

  // Read data captured one edge before the answer
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      avs_readdata <= 32'h0000_0000;
    else if (ce && avs_read && !ack)
      avs_readdata <= rd_cur;
  end

  // Configuration registers
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl <= CTRL_RST;
      idle_cur <= IDLE_CUR_RST;
      deep_dly <= DEEP_DLY_RST;
      flash_min <= FLASH_MIN_RST;
      irq_mask <= '0;
    end
    else if (reg_wr)
    begin
      case (avs_address)
        REG_CTRL: ctrl <= wdat[3:0];
        REG_IDLE_CUR: idle_cur <= wdat[15:0];
        REG_DEEP_DLY: deep_dly <= wdat[15:0];
        REG_FLASH_MIN: flash_min <= wdat[15:0];
        REG_IRQ_MASK: irq_mask <= wdat[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  // Sticky status, write one to clear, a new event wins
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      irq_stat <= '0;
    else if (ce)
    begin
      if (reg_wr && avs_address == REG_IRQ_STAT)
        irq_stat <= (irq_stat & ~lane_dat[IRQ_W-1:0]) | irq_ev;
      else
        irq_stat <= irq_stat | irq_ev;
    end
  end

  assign irq_ev[IRQ_WAKE] = trip_now && !wake_trip;
  assign irq_ev[IRQ_MODE] = state != next_state;
  assign irq_ev[IRQ_FLASH] = flash_write_req && !flash_ok;
  assign irq = |(irq_stat & irq_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Wake comparator

  // Threshold select and crossing in either direction
  assign thresh = wake_th({ctrl[CTRL_SEL_HI], ctrl[CTRL_SEL_LO], ctrl[CTRL_WAKE_BIT]});
  assign th_s = {1'b0, thresh};
  assign sense_x = {meas.sense_uv[15], meas.sense_uv};
  assign trip_now = thresh != 16'h0000 && (sense_x > th_s || sense_x < -th_s);

  // Registered trip level
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      wake_trip <= 1'b0;
    else if (ce)
      wake_trip <= trip_now;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash write gate

  assign flash_ok = meas.voltage_mv >= flash_min;

  // Grant only at or above the minimum voltage
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      flash_write_grant <= 1'b0;
    else if (ce)
      flash_write_grant <= flash_write_req && flash_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host line watch

  // Three-stage synchroniser, level accepted when stages two and three agree
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      line_s <= 3'h7;
      line_lvl <= 1'b1;
    end
    else if (ce)
    begin
      line_s <= {line_s[1:0], comm_line_i};
      if (line_s[1] == line_s[2])
        line_lvl <= line_s[2];
    end
  end

  // Falling edge of the accepted level is host activity
  assign comm_act = line_lvl && line_s[1] == line_s[2] && !line_s[2];

  // Protection status change detector
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      prot_prev <= 8'h00;
    else if (ce)
      prot_prev <= prot_status;
  end

  assign prot_chg = prot_status != prot_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Power mode sequencer

  assign cur_mag = meas.mean_current_reading[15] ? 16'(-meas.mean_current_reading)
                                                 : meas.mean_current_reading;
  assign qual = ctrl[CTRL_IDLE_EN] && cur_mag < idle_cur;

  // Next mode
  always_comb
  begin
    next_state = state;
    case (state)
      ST_NORMAL:
        if (qual)
          next_state = ST_CAL;
      ST_CAL:
        if (!qual)
          next_state = ST_NORMAL;
        else if (adc_cal_done)
          next_state = ST_IDLE;
      ST_IDLE:
        if (!qual || prot_chg || wake_trip)
          next_state = ST_NORMAL;
        else if (deep_dly != 16'h0000 && (dcount == 16'h0000 || deep_idle_flag))
          next_state = ST_DEEP;
      ST_DEEP:
        if (comm_act)
          next_state = ST_STALL;
      ST_STALL:
        if (stall_cnt == '0)
          next_state = ST_NORMAL;
      default:
        next_state = ST_NORMAL;
    endcase
  end

  // Mode register
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      state <= ST_NORMAL;
    else if (ce)
      state <= next_state;
  end

  // Deep-idle countdown, reloaded on idle entry
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      dcount <= 16'h0000;
    else if (ce)
    begin
      if (state == ST_CAL && next_state == ST_IDLE)
        dcount <= deep_dly;
      else if (state == ST_IDLE && meas_tick && dcount != 16'h0000)
        dcount <= dcount - 16'h0001;
    end
  end

  // Line hold time while the fast oscillator restarts
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      stall_cnt <= '0;
    else if (ce)
    begin
      if (state == ST_DEEP && comm_act)
        stall_cnt <= SW'(STALL_CYC - 1);
      else if (state == ST_STALL && stall_cnt != '0)
        stall_cnt <= stall_cnt - 1'b1;
    end
  end

  // Deep-idle flag, set by command, cleared on wake; set wins
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      deep_idle_flag <= 1'b0;
    else if (ce)
    begin
      if (cmd_wr)
        deep_idle_flag <= 1'b1;
      else if (state == ST_DEEP && comm_act)
        deep_idle_flag <= 1'b0;
    end
  end

  // First single-wire message after a deep-idle wake is dropped
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      drop_next_msg <= 1'b0;
    else if (ce)
    begin
      if (state == ST_DEEP && comm_act && single_wire_mode)
        drop_next_msg <= 1'b1;
      else if (msg_done)
        drop_next_msg <= 1'b0;
    end
  end

  // Periodic measurement and data set refresh in every state except calibration and line hold
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meas_start <= 1'b0;
      dataset_update <= 1'b0;
      adc_cal_start <= 1'b0;
    end
    else if (ce)
    begin
      meas_start <= meas_tick && state != ST_STALL && state != ST_CAL;
      dataset_update <= meas_tick && state != ST_STALL && state != ST_CAL;
      adc_cal_start <= state == ST_NORMAL && next_state == ST_CAL;
    end
  end

  // Mode decode, oscillator and line hold
  always_comb
  begin
    case (state)
      ST_IDLE: power_mode = PM_IDLE;
      ST_DEEP: power_mode = PM_DEEP;
      default: power_mode = PM_NORMAL;
    endcase
  end

  assign hf_osc_en = state != ST_DEEP;
  assign comm_line_oe = state == ST_STALL;
  assign comm_line_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Run length of the line hold
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      oe_run <= '0;
    else if (ce)
    begin
      if (comm_line_oe && oe_run != '1)
        oe_run <= oe_run + 1'b1;
      else if (!comm_line_oe)
        oe_run <= '0;
    end
  end

  a_wake_level: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && ctrl[3:1] == 3'b111 && meas.sense_uv < -16'sd10001 |=> wake_trip)
    else $error("wake comparator missed a crossing");

  a_wake_off: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && ctrl[CTRL_SEL_HI:CTRL_SEL_LO] == 2'b00 |=> !wake_trip)
    else $error("disabled wake comparator tripped");

  a_wake_irq: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && trip_now && !wake_trip |=> irq_stat[IRQ_WAKE] && wake_trip)
    else $error("wake crossing raised no interrupt");

  a_flash_block: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && flash_write_req && meas.voltage_mv < flash_min |=> !flash_write_grant)
    else $error("flash write granted at low voltage");

  a_cal_normal: assert property (@(posedge mclk) disable iff (!reset_n)
    state inside {ST_CAL, ST_STALL} |-> power_mode == PM_NORMAL)
    else $error("transient mode shown as low power");

  a_idle_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && state == ST_NORMAL && !qual |=> state == ST_NORMAL)
    else $error("idle entry without qualification");

  a_cal_first: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && state == ST_NORMAL && qual |=> state == ST_CAL && adc_cal_start)
    else $error("calibration skipped on idle entry");

  a_idle_meas: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && state == ST_IDLE && meas_tick |=> meas_start && dataset_update)
    else $error("idle tick took no measurement");

  a_idle_exit: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && state == ST_IDLE && (wake_trip || prot_chg) |=> state == ST_NORMAL)
    else $error("idle not left on wake or protection change");

  a_deep_off: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && state == ST_IDLE && deep_dly == 16'h0000 |=> state != ST_DEEP)
    else $error("deep idle entered with zero delay");

  a_deep_wake: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && state == ST_DEEP && comm_act && !cmd_wr |-> ##1 (comm_line_oe && hf_osc_en && !deep_idle_flag))
    else $error("host activity did not end deep idle");

  a_stall_max: assert property (@(posedge mclk) disable iff (!reset_n)
    comm_line_oe |-> oe_run < SW'(STALL_CYC))
    else $error("line held low too long");

  a_drop_first: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && state == ST_DEEP && comm_act && single_wire_mode |=> drop_next_msg)
    else $error("single-wire wake message not dropped");

  a_timer_load: assert property (@(posedge mclk) disable iff (!reset_n)
    ce && state == ST_CAL && next_state == ST_IDLE |=> dcount == $past(deep_dly))
    else $error("deep idle timer not reloaded");

endmodule
`default_nettype wire

// ==== tb/gpmc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpmc_host
(
  // Clock and resolved line level
  input wire logic mclk,
  input wire logic line,
  // Host drive and message end
  output logic host_low,
  output logic msg_done
);
  initial host_low = 1'b0;
  initial msg_done = 1'b0;
  // Sends one message, retrying when the first may have been lost
  task automatic send_msg(input int tries);
    int k;
    repeat (tries)
    begin
      @(posedge mclk) host_low <= 1'b1;
      repeat (4) @(posedge mclk);
      host_low <= 1'b0;
      k = 0;
      @(negedge mclk);
      while (!line && k < 5000)
      begin
        k++;
        @(negedge mclk);
      end
      @(posedge mclk) msg_done <= 1'b1;
      @(posedge mclk) msg_done <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== tb/tb_gauge_power_mode_control.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
`define WAIT(c) begin @(negedge mclk); while (!(c)) @(negedge mclk); end
module tb_gauge_power_mode_control;
  import gpmc_pkg::*;
  localparam int SC = 20;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic [5:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic wr_s = 1'b0;
  gpmc_meas_t meas = '{16'sd100, 16'h0CE4, 16'sd0};
  logic meas_tick = 1'b0;
  logic [7:0] prot_status = 8'h00;
  logic adc_cal_done = 1'b0;
  logic flash_write_req = 1'b0;
  logic single_wire_mode = 1'b0;
  logic meas_start, dataset_update, adc_cal_start, flash_write_grant;
  logic comm_line_o, comm_line_oe, drop_next_msg, hf_osc_en, wake_trip, irq;
  logic host_low, msg_done, line;
  gpmc_pmode_t power_mode;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int stall_cnt = 0;
  bit drop_seen = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [15:0] th[8] = '{16'h0000, 16'h0000, TH_1P25, TH_2P5, TH_2P5, TH_5, TH_5, TH_10};
  ////////////////////////////////////////////////////////////////////////////
  // Clock and open-drain line with pull-up
  always #2.5 mclk = ~mclk;
  assign line = host_low ? 1'b0 : (comm_line_oe ? comm_line_o : 1'b1);
  gpmc_top #(.STALL_CYC(SC)) dut (.mclk(mclk), .reset_n(reset_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .meas(meas), .meas_tick(meas_tick),
    .prot_status(prot_status), .adc_cal_done(adc_cal_done), .meas_start(meas_start),
    .dataset_update(dataset_update), .adc_cal_start(adc_cal_start), .flash_write_req(flash_write_req),
    .flash_write_grant(flash_write_grant), .comm_line_i(line), .single_wire_mode(single_wire_mode),
    .msg_done(msg_done), .comm_line_o(comm_line_o), .comm_line_oe(comm_line_oe), .drop_next_msg(drop_next_msg),
    .power_mode(power_mode), .hf_osc_en(hf_osc_en), .wake_trip(wake_trip), .irq(irq));
  gpmc_host host (.mclk(mclk), .line(line), .host_low(host_low), .msg_done(msg_done));
  // Settled samples, stall length, watchdog
  always @(negedge mclk)
  begin
    wr_s <= avs_waitrequest;
    if (comm_line_oe) stall_cnt++;
    if (drop_next_msg) drop_seen = 1'b1;
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      end_sim();
    end
  end
  // Read results against the oldest expectation
  always @(posedge mclk)
  begin
    if (avs_read && !wr_s && exp_q.size() > 0)
    begin
      `CHK(avs_readdata & msk_q[0], exp_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus cycle; held until waitrequest is seen low
  task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] d, input logic [31:0] m);
    @(posedge mclk);
    if (!wr)
    begin
      exp_q.push_back(d & m);
      msk_q.push_back(m);
    end
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge mclk);
    while (wr_s) @(posedge mclk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Measurement tick and its pulses
  task automatic tick();
    @(posedge mclk) meas_tick <= 1'b1;
    @(posedge mclk) meas_tick <= 1'b0;
    @(negedge mclk);
    `CHK({meas_start, dataset_update}, 2'b11)
  endtask
  // Finish calibration, idle follows on the next edge
  task automatic cal();
    `WAIT(adc_cal_start)
    `CHK(power_mode, PM_NORMAL)
    @(posedge mclk) adc_cal_done <= 1'b1;
    @(posedge mclk) adc_cal_done <= 1'b0;
    @(negedge mclk);
    `CHK(power_mode, PM_IDLE)
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [15:0] v;
    void'($urandom(69));
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    bus(0, REG_CTRL, 32'(CTRL_RST), 32'hFFFF_FFFF);
    bus(0, REG_FLASH_MIN, 32'(FLASH_MIN_RST), 32'hFFFF_FFFF);
    bus(0, REG_STATUS, 32'h0000_0008, 32'h0000_000B);
    bus(0, 6'h3C, 32'h0000_0000, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++)
    begin
      bus(1, REG_CTRL, {28'h0, i[0], i[2], i[1], 1'b0}, '0);
      bus(0, REG_THRESH, 32'(th[i]), 32'hFFFF_FFFF);
    end
    bus(1, REG_IRQ_MASK, 32'h0000_0001, '0);
    bus(1, REG_CTRL, 32'h0000_000E, '0);
    for (int s = 0; s < 2; s++)
    begin
      @(posedge mclk) meas.sense_uv <= s ? -16'sd12000 : 16'sd12000;
      `WAIT(irq)
      `CHK(wake_trip, 1'b1)
      bus(1, REG_IRQ_MASK, 32'h0000_0000, '0);
      @(negedge mclk);
      `CHK(irq, 1'b0)
      bus(0, REG_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
      @(posedge mclk) meas.sense_uv <= 16'sd0;
      bus(1, REG_IRQ_STAT, 32'h0000_0001, '0);
      bus(0, REG_IRQ_STAT, 32'h0000_0000, 32'h0000_0001);
      bus(1, REG_IRQ_MASK, 32'h0000_0001, '0);
      @(negedge mclk);
      `CHK(irq, 1'b0)
    end
    bus(1, REG_CTRL, 32'h0000_0008, '0);
    @(posedge mclk) meas.sense_uv <= 16'sd20000;
    repeat (6) @(negedge mclk);
    `CHK(wake_trip, 1'b0)
    @(posedge mclk) flash_write_req <= 1'b1;
    for (int j = 0; j < 6; j++)
    begin
      v = (j < 2) ? FLASH_MIN_RST - 16'h0001 + 16'(j) : FLASH_MIN_RST - 16'h0064 + 16'($urandom_range(200));
      @(posedge mclk) meas.voltage_mv <= v;
      repeat (3) @(negedge mclk);
      `CHK(flash_write_grant, v >= FLASH_MIN_RST)
    end
    bus(1, REG_DEEP_DLY, 32'h0000_0002, '0);
    bus(1, REG_CTRL, 32'h0000_0001, '0);
    tick();
    // A tick while the clock enable is low must leave meas_start frozen
    @(posedge mclk) ce <= 1'b0;
    @(posedge mclk) meas_tick <= 1'b1;
    @(posedge mclk) meas_tick <= 1'b0;
    @(negedge mclk);
    `CHK(meas_start, 1'b0)
    @(posedge mclk) ce <= 1'b1;
    @(posedge mclk) meas.mean_current_reading <= -16'sd5;
    cal();
    bus(0, REG_STATUS, 32'h0002_0001, 32'hFFFF_0003);
    tick();
    `CHK(power_mode, PM_IDLE)
    tick();
    `WAIT(power_mode == PM_DEEP)
    `CHK(hf_osc_en, 1'b0)
    tick();
    @(posedge mclk) meas.mean_current_reading <= 16'sd50;
    @(posedge mclk) single_wire_mode <= 1'b1;
    host.send_msg(2);
    `CHK(stall_cnt, SC)
    `CHK(drop_seen, 1'b1)
    `CHK(drop_next_msg, 1'b0)
    `CHK(hf_osc_en, 1'b1)
    `CHK(power_mode, PM_NORMAL)
    @(posedge mclk) meas.mean_current_reading <= -16'sd5;
    cal();
    bus(0, REG_STATUS, 32'h0002_0001, 32'hFFFF_0003);
    bus(1, REG_DEEP_DLY, 32'h0000_0000, '0);
    @(posedge mclk) prot_status <= 8'h01;
    repeat (2) @(negedge mclk);
    `CHK(power_mode, PM_NORMAL)
    cal();
    repeat (3) tick();
    `CHK(power_mode, PM_IDLE)
    @(posedge mclk) meas.mean_current_reading <= 16'sd50;
    repeat (2) @(negedge mclk);
    `CHK(power_mode, PM_NORMAL)
    bus(1, REG_DEEP_DLY, 32'h0000_0064, '0);
    @(posedge mclk) meas.mean_current_reading <= -16'sd5;
    cal();
    bus(1, REG_CMD, 32'h0000_0001, '0);
    bus(0, REG_STATUS, 32'h0000_0012, 32'h0000_001B);
    @(posedge mclk) single_wire_mode <= 1'b0;
    host.send_msg(1);
    `CHK(stall_cnt, 2 * SC)
    `CHK(drop_next_msg, 1'b0)
    bus(0, REG_STATUS, 32'h0000_0000, 32'h0000_0010);
    bus(0, REG_IRQ_STAT, 32'h0000_0006, 32'h0000_0006);
    repeat (2) @(posedge mclk);
    end_sim();
  end
endmodule
`default_nettype wire
